// ### hw/mcl_amp_limit.sv
// Acceleration limiter and back-EMF estimates.
// Assumes speed, currents and command are sampled on pclk.
`timescale 1ns/1ps
module mcl_amp_limit
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Settings
  input  wire logic [3:0] acc_sel,
  input  wire logic [6:0] res_set,
  input  wire logic [6:0] kt_set,
  input  wire logic       closed_loop,
  input  wire mcl_meas_s  meas,
  // Results
  output logic [8:0]      amp_out,
  output logic            limiting,
  output logic [8:0]      est_kt,
  output logic [8:0]      est_r
);

  typedef struct packed {
    logic [8:0] amp;
    logic       lim;
    logic [8:0] ekt;
    logic [8:0] er;
  } mcl_amp_s;

  mcl_amp_s   s_reg, s_next;
  logic [7:0] ilim;
  logic [8:0] ulim;
  logic [8:0] idrop;

  // Voltage model; the limit uses no sensed current, est_r uses phase U current
  always_comb
  begin
    ilim  = step_thr(acc_sel, ACC_STEP);
    ulim  = sat9(18'((15'(ilim) * 15'(res_set)) >> R_SHIFT)
                 + 18'((17'(meas.speed) * 17'(kt_set)) >> KT_SHIFT));
    idrop = sat9(18'((15'(meas.phase_u_i) * 15'(res_set)) >> R_SHIFT));
    s_next     = s_reg;
    s_next.ekt = sat9(18'((17'(meas.speed) * 17'(kt_set)) >> KT_SHIFT));
    s_next.er  = (meas.amp_cmd > idrop) ? meas.amp_cmd - idrop : 9'h000;
    // Clamp only under closed-loop commutation; never a fault
    s_next.lim = closed_loop && (meas.amp_cmd > ulim);
    s_next.amp = s_next.lim ? ulim : meas.amp_cmd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign amp_out  = s_reg.amp;
  assign limiting = s_reg.lim;
  assign est_kt   = s_reg.ekt;
  assign est_r    = s_reg.er;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ACCEL_OPEN_LOOP: assert property (!closed_loop |=> amp_out == $past(meas.amp_cmd))
    else $error("amplitude limited during open loop");
  AST_ACCEL_CAP: assert property (limiting |-> amp_out < $past(meas.amp_cmd))
    else $error("limit flag without a reduced amplitude");

endmodule // mcl_amp_limit

// ### hw/mcl_lock_ctrl.sv
// Current limit and lock detect supervisor with an APB register file.
// Assumes all motor inputs are synchronous to pclk and zero cross,
// commutation and handoff strobes are one-cycle pulses.
//
// Summary of operation
// - Overcurrent trip uses a fixed threshold; no register can disable it.
// - Phase overcurrent tri-states the bridge; drive resumes once trip clears.
// - Acceleration limit caps amplitude; threshold picked by four-bit select.
// - Limit is resistance times current plus speed times emf constant.
// - Acceleration limiting keeps the motor running and raises no fault.
// - Acceleration limit applies only under closed-loop commutation.
// - Six enable bits disable each lock scheme and no-motor check.
// - Any enabled lock sets the motor locked flag.
// - Fault cause bits clear when the motor restarts.
// - Cause bits set even when the matching scheme is disabled.
// - Lock or no-motor puts all phase drivers into high impedance.
// - Each switch to high impedance starts the anti-surge process.
// - After a fault the retry delay runs, then restart is automatic.
// - Low-side current above three-bit selected threshold means lock.
// - Back-EMF estimated from phase U current and from speed.
// - Speed estimate well above amplitude for persist time means lock.
// - Back-EMF integral per half cycle forms the measured constant.
// - Measured constant outside selected window for persist time means lock.
// - At open-to-closed handoff, phase U at most 140 mA means no motor.
// - Open loop past handoff, no zero cross for one cycle means lock.
// - Closed loop commutation period over twice the previous means lock.
// - Mechanical and inductive anti-surge modes each have an enable.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module mcl_lock_ctrl
  import mcl_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Motor status inputs
  input  wire logic        start_cmd,
  input  wire logic        oc_trip,
  input  wire logic        closed_loop,
  input  wire logic        handoff_over,
  input  wire logic        ol_to_cl,
  input  wire logic        comm_edge,
  input  wire logic        bemf_zc,
  input  wire mcl_meas_s   meas,
  // Bridge and surge control
  output logic             bridge_hiz,
  output logic [8:0]       drive_amp,
  output logic             surge_start,
  output logic             mech_surge,
  output logic             ind_surge,
  output logic             restart,
  output logic             accel_limiting
);

  typedef struct packed {
    mcl_state_e         st;
    logic [31:0]        ctrl;
    logic [31:0]        coef;
    logic [31:0]        prdata;
    logic               locked;
    logic [5:0]         cause;
    logic               hiz;
    logic               restart;
    logic               surge_go;
    logic [SURGE_W-1:0] surge_cnt;
    logic [RETRY_W-1:0] retry_cnt;
    logic [15:0]        comm_cnt;
    logic [15:0]        comm_prev;
    logic               prev_ok;
    logic               cnt_full;
    logic [2:0]         ol_steps;
    logic [15:0]        ktc_acc;
    logic [15:0]        ktc;
    logic               ktc_ok;
  } mcl_core_s;

  mcl_core_s  s_reg, s_next;
  logic       run;
  logic       apb_setup;
  logic       apb_wr;
  logic [5:0] det;
  logic [5:0] lock_en;
  logic       lock_hit;
  logic       spd_hit;
  logic       kt_hit;
  logic [8:0] amp;
  logic [8:0] est_kt;
  logic [8:0] est_r;

  // Decoded address lies inside the map
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_COEF) || (a == ADDR_STAT) || (a == ADDR_EST);
  endfunction

  // Measured constant outside the window around the programmed one
  function automatic logic kt_outside(input logic [15:0] ktc, input logic [6:0] kt,
                                      input logic [1:0] sel);
    logic [15:0] ref_v;
    logic [15:0] tol;
    ref_v      = 16'(kt) << KTC_SHIFT;
    tol        = ref_v >> (3'(sel) + 3'h1);
    kt_outside = (ktc < ref_v - tol) || (ktc > ref_v + tol);
  endfunction

  assign run       = (s_reg.st == ST_RUN);
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign lock_en   = s_reg.ctrl[CTRL_LEN_LSB +: 6];

  // Acceleration limiter and estimates
  mcl_amp_limit u_amp (
    .pclk        (pclk),
    .presetn     (presetn),
    .acc_sel     (s_reg.ctrl[CTRL_ACC_LSB +: 4]),
    .res_set     (s_reg.coef[COEF_R_LSB +: 7]),
    .kt_set      (s_reg.coef[COEF_KT_LSB +: 7]),
    .closed_loop (closed_loop),
    .meas        (meas),
    .amp_out     (amp),
    .limiting    (accel_limiting),
    .est_kt      (est_kt),
    .est_r       (est_r)
  );

  // Abnormal speed: speed-based estimate far above amplitude
  mcl_persist #(.N(PERSIST_CYC)) u_spd (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (!run),
    .cond    (closed_loop && ({1'b0, est_kt} > {1'b0, amp} + SPD_MARGIN)),
    .hit     (spd_hit)
  );

  // Abnormal constant: integral leaves its window
  mcl_persist #(.N(PERSIST_CYC)) u_kt (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (!run),
    .cond    (closed_loop && s_reg.ktc_ok && kt_outside(s_reg.ktc,
              s_reg.coef[COEF_KT_LSB +: 7], s_reg.ctrl[CTRL_WIN_LSB +: 2])),
    .hit     (kt_hit)
  );

  // Six detectors, indexed by scheme; only meaningful while driving
  always_comb
  begin
    det         = '0;
    det[LK_CUR] = meas.lowside_i > step_thr({1'b0, s_reg.ctrl[CTRL_LCK_LSB +: 3]},
                                            LCK_STEP);
    det[LK_SPD] = spd_hit;
    det[LK_KT]  = kt_hit;
    det[LK_NOM] = ol_to_cl && (meas.phase_u_i <= NOMOTOR_CNT);
    det[LK_OL]  = !closed_loop && handoff_over && (s_reg.ol_steps == OL_STEPS);
    det[LK_CL]  = closed_loop && s_reg.prev_ok
                  && ({1'b0, s_reg.comm_cnt} > {s_reg.comm_prev, 1'b0});
    det         = run ? det : 6'h00;
  end

  assign lock_hit = |(det & lock_en);

  // Next state: registers, period tracking, sequencing
  always_comb
  begin
    s_next          = s_reg;
    s_next.restart  = 1'b0;
    s_next.surge_go = 1'b0;

    // Register writes take effect in the access phase
    if (apb_wr && paddr == ADDR_CTRL)
      s_next.ctrl = pwdata & CTRL_MASK;
    if (apb_wr && paddr == ADDR_COEF)
      s_next.coef = pwdata & COEF_MASK;

    // Read data is captured in setup so it stands as a flop in access
    if (apb_setup)
    begin
      case (paddr)
        ADDR_CTRL: s_next.prdata = s_reg.ctrl;
        ADDR_COEF: s_next.prdata = s_reg.coef;
        ADDR_STAT: s_next.prdata = {14'h0000, s_reg.st, 2'h0, s_reg.cause,
                                    5'h00, s_reg.hiz, oc_trip, s_reg.locked};
        ADDR_EST:  s_next.prdata = {s_reg.ktc, 7'h00, est_kt};
        default:   s_next.prdata = 32'h0000_0000;
      endcase
    end

    // Commutation period of the present and previous step
    if (run && comm_edge)
    begin
      s_next.comm_prev = s_reg.comm_cnt;
      s_next.comm_cnt  = 16'h0000;
      // First period after start is partial, never a reference
      s_next.prev_ok   = closed_loop && s_reg.cnt_full;
      s_next.cnt_full  = 1'b1;
    end
    else if (run)
      s_next.comm_cnt = (s_reg.comm_cnt == CNT_MAX) ? CNT_MAX : s_reg.comm_cnt + 16'h0001;
    else
    begin
      s_next.comm_cnt = 16'h0000;
      s_next.prev_ok  = 1'b0;
      s_next.cnt_full = 1'b0;
    end

    // Open-loop steps past handoff without a zero cross
    if (!run || closed_loop || !handoff_over || bemf_zc)
      s_next.ol_steps = 3'h0;
    else if (comm_edge && s_reg.ol_steps != OL_STEPS)
      s_next.ol_steps = s_reg.ol_steps + 3'h1;

    // Back-EMF integral over each half cycle, latched at zero cross
    if (!run)
    begin
      s_next.ktc_acc = 16'h0000;
      s_next.ktc_ok  = 1'b0;
    end
    else if (bemf_zc)
    begin
      s_next.ktc     = s_reg.ktc_acc;
      s_next.ktc_acc = 16'(meas.bemf);
      s_next.ktc_ok  = 1'b1;
    end
    else if (s_reg.ktc_acc <= CNT_MAX - 16'(meas.bemf))
      s_next.ktc_acc = s_reg.ktc_acc + 16'(meas.bemf);

    // Drive sequencing
    case (s_reg.st)
      ST_IDLE:
      begin
        if (start_cmd)
        begin
          s_next.st      = ST_RUN;
          s_next.restart = 1'b1;
          s_next.cause   = 6'h00;
          s_next.locked  = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (lock_hit)
        begin
          s_next.st        = ST_OFF;
          s_next.retry_cnt = RETRY_W'(RETRY_CYCLES - 1);
        end
        else if (!start_cmd)
          s_next.st = ST_IDLE;
      end
      ST_OFF:
      begin
        if (!start_cmd)
          s_next.st = ST_IDLE;
        else if (s_reg.retry_cnt == '0)
        begin
          s_next.st      = ST_RUN;
          s_next.restart = 1'b1;
          s_next.cause   = 6'h00;
          s_next.locked  = 1'b0;
        end
        else
          s_next.retry_cnt = s_reg.retry_cnt - RETRY_W'(1);
      end
      default: s_next.st = ST_IDLE;
    endcase

    // New detections win over the restart clear
    s_next.cause = s_next.cause | det;
    if (lock_hit)
      s_next.locked = 1'b1;

    // Fixed-threshold trip overrides everything and self-recovers
    s_next.hiz = (s_next.st != ST_RUN) || oc_trip;

    // Every entry to high impedance starts the anti-surge window
    if (s_next.hiz && !s_reg.hiz)
    begin
      s_next.surge_go  = 1'b1;
      s_next.surge_cnt = SURGE_W'(SURGE_CYC);
    end
    else if (s_reg.surge_cnt != '0)
      s_next.surge_cnt = s_reg.surge_cnt - SURGE_W'(1);
  end

  // State register; bridge starts tri-stated
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg      <= '0;
      s_reg.st   <= ST_IDLE;
      s_reg.ctrl <= CTRL_RST;
      s_reg.coef <= COEF_RST;
      s_reg.hiz  <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // Outputs
  assign prdata      = s_reg.prdata;
  assign pready      = 1'b1; // Zero wait states
  assign pslverr     = psel && penable && !addr_ok(paddr);
  assign bridge_hiz  = s_reg.hiz;
  assign drive_amp   = s_reg.hiz ? 9'h000 : amp;
  assign surge_start = s_reg.surge_go;
  assign restart     = s_reg.restart;
  // Each surge mode may be switched off on its own
  assign mech_surge  = (s_reg.surge_cnt != '0) && s_reg.ctrl[CTRL_MEN_BIT];
  assign ind_surge   = (s_reg.surge_cnt != '0) && s_reg.ctrl[CTRL_IEN_BIT];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OC_HIZ: assert property (oc_trip |=> bridge_hiz)
    else $error("overcurrent did not tri-state the bridge");
  AST_OC_RESUME: assert property (run && !oc_trip && !lock_hit && start_cmd |=> !bridge_hiz)
    else $error("drive did not resume after overcurrent");
  AST_LOCK_FLAG: assert property (lock_hit |=> s_reg.locked && s_reg.st == ST_OFF)
    else $error("lock did not set flag");
  AST_LOCK_HIZ: assert property (lock_hit |=> bridge_hiz [*3])
    else $error("bridge driven after lock");
  AST_SURGE: assert property ($rose(bridge_hiz) |-> surge_start ##1 !surge_start)
    else $error("no anti-surge pulse on tri-state");
  AST_CAUSE_DISABLED: assert property (det[LK_CUR] && !lock_en[LK_CUR] |=> s_reg.cause[LK_CUR])
    else $error("cause missing for disabled scheme");
  AST_RESTART_CLEAR: assert property (restart |-> s_reg.cause == $past(det))
    else $error("cause not cleared on restart");
  AST_RETRY_HOLD: assert property (lock_hit ##1 start_cmd [*8] |-> !restart)
    else $error("restart came before the retry delay");
  AST_PERIOD: assert property (run && closed_loop && s_reg.prev_ok && lock_en[LK_CL]
                               && 32'(s_reg.comm_cnt) > 32'(s_reg.comm_prev) * 2
                               |=> s_reg.cause[LK_CL] && bridge_hiz)
    else $error("period lock not taken");
  AST_NOMOTOR: assert property (run && ol_to_cl && meas.phase_u_i <= NOMOTOR_CNT
                                |=> s_reg.cause[LK_NOM])
    else $error("no-motor cause missing");

  COV_LOCK_RETRY: cover property (lock_hit ##[1:1000] restart);
  COV_OC_TRIP: cover property (run ##1 oc_trip ##1 !oc_trip);
  COV_ACCEL: cover property (accel_limiting && run);

endmodule // mcl_lock_ctrl

// ### hw/mcl_persist.sv
// Persistence filter: flags a condition that has held without a break.
// Assumes cond is synchronous to pclk; clr restarts the count.
`timescale 1ns/1ps
module mcl_persist
  import mcl_pkg::*;
#(
  parameter int N = PERSIST_CYC
)(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Condition in, flag out
  input  wire logic clr,
  input  wire logic cond,
  output logic      hit
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        hit;
  } mcl_pers_s;

  mcl_pers_s s_reg, s_next;

  // Count while the condition holds, saturate at the limit
  always_comb
  begin
    s_next = s_reg;
    if (clr || !cond)
      s_next.cnt = '0;
    else if (s_reg.cnt != 16'(N))
      s_next.cnt = s_reg.cnt + 16'h0001;
    s_next.hit = (s_next.cnt == 16'(N));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign hit = s_reg.hit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PERSIST_CAUSE: assert property ($rose(hit) |-> $past(cond) && !$past(clr))
    else $error("persist flag rose without its condition");

endmodule // mcl_persist

// ### shared/mcl_pkg.sv
// Constants, carrier types and helper functions of the motor current
// limit and lock detect supervisor. Assumes a 40 MHz APB clock.
package mcl_pkg;

  // Clock rate
  localparam int CLK_MHZ = 40;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COEF = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_EST  = 8'h0c;

  // Field positions
  localparam int CTRL_ACC_LSB = 0;
  localparam int CTRL_LCK_LSB = 4;
  localparam int CTRL_WIN_LSB = 8;
  localparam int CTRL_MEN_BIT = 12;
  localparam int CTRL_IEN_BIT = 13;
  localparam int CTRL_LEN_LSB = 16;
  localparam int COEF_R_LSB   = 0;
  localparam int COEF_KT_LSB  = 8;

  // Writable bits and reset values
  localparam logic [31:0] CTRL_MASK = 32'h003f_33ff;
  localparam logic [31:0] CTRL_RST  = 32'h003f_3074;
  localparam logic [31:0] COEF_MASK = 32'h0000_7f7f;
  localparam logic [31:0] COEF_RST  = 32'h0000_2010;

  // Cause bit positions, one per lock scheme
  localparam int LK_CUR = 0;
  localparam int LK_SPD = 1;
  localparam int LK_KT  = 2;
  localparam int LK_NOM = 3;
  localparam int LK_OL  = 4;
  localparam int LK_CL  = 5;

  // Times in their own units, counts derived from the clock
  localparam int PERSIST_TIME_US = 100;
  localparam int PERSIST_CYC     = PERSIST_TIME_US * CLK_MHZ;
  localparam int SURGE_TIME_US   = 20;
  localparam int SURGE_CYC       = SURGE_TIME_US * CLK_MHZ;
  localparam int RETRY_TIME_US   = 1000;
  localparam int RETRY_W         = 24;
  localparam int SURGE_W         = 12;

  // Scaling of the analog estimates
  localparam int          NOMOTOR_MA  = 140;
  localparam int          CUR_LSB_MA  = 10;
  localparam logic [7:0]  NOMOTOR_CNT = 8'(NOMOTOR_MA / CUR_LSB_MA);
  localparam logic [7:0]  ACC_STEP    = 8'h08;
  localparam logic [7:0]  LCK_STEP    = 8'h1c;
  localparam int          R_SHIFT     = 4;
  localparam int          KT_SHIFT    = 6;
  localparam int          KTC_SHIFT   = 4;
  localparam logic [9:0]  SPD_MARGIN  = 10'h010;
  localparam logic [2:0]  OL_STEPS    = 3'h6;
  localparam logic [15:0] CNT_MAX     = 16'hffff;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_OFF} mcl_state_e;

  // Sampled motor measurements
  typedef struct packed {
    logic [9:0] speed;
    logic [7:0] lowside_i;
    logic [7:0] phase_u_i;
    logic [8:0] amp_cmd;
    logic [7:0] bemf;
  } mcl_meas_s;

  // Current threshold from a select code, a quarter step per code
  function automatic logic [7:0] step_thr(input logic [3:0] sel, input logic [7:0] step);
    step_thr = 8'((12'(sel) + 12'h001) * 12'(step) >> 2);
  endfunction

  // Clamp an 18-bit sum to a 9-bit amplitude
  function automatic logic [8:0] sat9(input logic [17:0] v);
    sat9 = (|v[17:9]) ? 9'h1ff : v[8:0];
  endfunction

endpackage

// ### test/mcl_lock_ctrl_bench.sv
// Bench of the lock supervisor: APB tasks and motor fault sequences.
// Assumes the motor model beside it and a shortened retry delay.
`timescale 1ns/1ps
module mcl_lock_ctrl_bench
  import mcl_pkg::*;
;
  localparam int RC = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0]  paddr, period, load_i;
  logic [31:0] pwdata, prdata, q;
  logic        start_cmd, oc_trip, closed_loop, handoff_over, ol_to_cl, stuck;
  logic        comm_edge, bemf_zc, bridge_hiz, surge_start, mech_surge, ind_surge;
  logic        restart, accel_limiting;
  logic [9:0]  spd;
  logic [8:0]  amp, drive_amp;
  mcl_meas_s   meas;
  int          errors, tests_run, n;

  mcl_lock_ctrl #(.RETRY_CYCLES(RC)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .start_cmd, .oc_trip, .closed_loop,
    .handoff_over, .ol_to_cl, .comm_edge, .bemf_zc, .meas, .bridge_hiz, .drive_amp,
    .surge_start, .mech_surge, .ind_surge, .restart, .accel_limiting);
  mcl_motor_model motor (.pclk, .presetn, .bridge_hiz, .stuck, .period, .load_i, .spd,
    .amp, .meas, .comm_edge, .bemf_zc);

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
      if (k > 50)
      begin
        errors++;
        complete_run();
      end
    end
    while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_word(q & m, exp);
  endtask

  // Bounded wait for tri-state (sel 0) or a restart pulse (sel 1)
  task automatic wait_sig(input logic sel);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
      if (n > 200)
      begin
        errors++;
        complete_run();
      end
    end
    while ((sel ? restart : bridge_hiz) !== 1'b1);
  endtask

  // Stop and start again; a restart clears the cause bits
  task automatic go();
    @(posedge pclk);
    start_cmd <= 1'b0;
    repeat (2) @(posedge pclk);
    start_cmd <= 1'b1;
    wait_sig(1'b1);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, start_cmd, oc_trip, closed_loop} = 7'h00;
    {handoff_over, ol_to_cl, stuck, paddr, pwdata, period} = '0;
    load_i = 8'h20;
    spd = 10'h040;
    amp = 9'h100;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Register reset values, masks and refusals
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk_word(q, 32'h003f_3074);
    apb(1'b0, ADDR_COEF, 32'h0);
    chk_word(q, 32'h0000_2010);
    apb(1'b1, ADDR_CTRL, 32'hffff_ffff);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk_word(q, 32'h003f_33ff);
    apb(1'b1, 8'h10, 32'h1);
    chk_bit(slv, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk_word(q, 32'h0);
    apb(1'b1, ADDR_STAT, 32'hffff_ffff);
    stat(32'h0000_0004, 32'h0003_3f05);
    $display("test registers done");
    // Low-side trip with inductive surge disabled
    apb(1'b1, ADDR_CTRL, 32'h003f_1074);
    go();
    @(posedge pclk);
    load_i <= 8'h39;
    @(posedge pclk);
    @(negedge pclk);
    chk_bit(bridge_hiz, 1'b1);
    chk_bit(surge_start, 1'b1);
    @(posedge pclk);
    load_i <= 8'h20;
    @(negedge pclk);
    chk_bit(mech_surge, 1'b1);
    chk_bit(ind_surge, 1'b0);
    wait_sig(1'b1);
    chk_bit(n >= RC - 1 && n <= RC, 1'b1);
    stat(32'h0, 32'h0000_3f04);
    $display("test lock current done");
    // Disabled scheme still records its cause
    apb(1'b1, ADDR_CTRL, 32'h003e_3074);
    @(posedge pclk);
    load_i <= 8'h39;
    repeat (3) @(posedge pclk);
    load_i <= 8'h20;
    @(negedge pclk);
    chk_bit(bridge_hiz, 1'b0);
    stat(32'h0000_0100, 32'h0000_3f04);
    $display("test disabled scheme done");
    // Overcurrent trips with every lock scheme off
    apb(1'b1, ADDR_CTRL, 32'h0000_3074);
    go();
    @(posedge pclk);
    oc_trip <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk_bit(bridge_hiz, 1'b1);
    chk_bit(surge_start, 1'b1);
    @(posedge pclk);
    oc_trip <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk_bit(bridge_hiz, 1'b0);
    $display("test overcurrent done");
    // Closed-loop amplitude limit over several threshold codes
    apb(1'b1, ADDR_CTRL, 32'h003f_3074);
    go();
    @(posedge pclk);
    amp <= 9'h1ff;
    closed_loop <= 1'b1;
    for (int s = 0; s < 16; s += 5)
    begin
      apb(1'b1, ADDR_CTRL, 32'h003f_3070 | s);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk_word({23'h0, drive_amp}, 32'((s + 1) * 2 + 32));
      chk_bit(accel_limiting, 1'b1);
      chk_bit(bridge_hiz, 1'b0);
    end
    stat(32'h0, 32'h0000_3f01);
    @(posedge pclk);
    closed_loop <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk_bit(accel_limiting, 1'b0);
    chk_word({23'h0, drive_amp}, 32'h1ff);
    $display("test accel limit done");
    // No motor at the open to closed handoff
    apb(1'b1, ADDR_CTRL, 32'h003f_3074);
    @(posedge pclk);
    load_i <= 8'h0e;
    go();
    @(posedge pclk);
    closed_loop <= 1'b1;
    ol_to_cl <= 1'b1;
    @(posedge pclk);
    ol_to_cl <= 1'b0;
    wait_sig(1'b0);
    stat(32'h0000_0805, 32'h0000_3f05);
    $display("test no motor done");
    // Open-loop steps past handoff with no zero cross
    @(posedge pclk);
    load_i <= 8'h20;
    closed_loop <= 1'b0;
    go();
    @(posedge pclk);
    period <= 8'h0a;
    stuck <= 1'b1;
    handoff_over <= 1'b1;
    wait_sig(1'b0);
    stat(32'h0000_1005, 32'h0000_3f05);
    $display("test open loop stuck done");
    // Closed-loop step period more than doubles
    @(posedge pclk);
    handoff_over <= 1'b0;
    stuck <= 1'b0;
    go();
    @(posedge pclk);
    closed_loop <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_EST, 32'h0);
    chk_word(q, 32'h00a0_0020);
    stat(32'h0, 32'h0000_3f05);
    period <= 8'h28;
    wait_sig(1'b0);
    stat(32'h0000_2005, 32'h0000_3f05);
    $display("test closed loop stuck done");
    // Speed estimate far above the amplitude for the persist time
    @(posedge pclk);
    period <= 8'h00;
    amp <= 9'h010;
    spd <= 10'h060;
    go();
    repeat (3990) @(posedge pclk);
    wait_sig(1'b0);
    stat(32'h0000_0205, 32'h0000_3f05);
    $display("test abnormal speed done");
    complete_run();
  end
endmodule // mcl_lock_ctrl_bench

// ### test/mcl_motor_model.sv
// Motor and bridge model: turns drive state into measurements and strobes.
// Assumes the bench sets load, speed, command and step period as levels.
`timescale 1ns/1ps
module mcl_motor_model
  import mcl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bridge state and bench controls
  input  wire logic       bridge_hiz,
  input  wire logic       stuck,
  input  wire logic [7:0] period,
  input  wire logic [7:0] load_i,
  input  wire logic [9:0] spd,
  input  wire logic [8:0] amp,
  // Motor outputs
  output mcl_meas_s       meas,
  output logic            comm_edge,
  output logic            bemf_zc
);
  logic [7:0] cnt_reg;
  logic       step;

  // No current flows through a tri-stated bridge
  always_comb
  begin
    meas.speed     = spd;
    meas.lowside_i = bridge_hiz ? 8'h00 : load_i;
    meas.phase_u_i = bridge_hiz ? 8'h00 : load_i;
    meas.amp_cmd   = amp;
    meas.bemf      = bridge_hiz ? 8'h00 : 8'h10;
    step           = (period != 8'h00) && (cnt_reg >= period - 8'h01);
  end

  // Steps every period cycles; a stuck rotor gives no zero cross
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg   <= 8'h00;
      comm_edge <= 1'b0;
      bemf_zc   <= 1'b0;
    end
    else
    begin
      cnt_reg   <= step ? 8'h00 : cnt_reg + 8'h01;
      comm_edge <= step;
      bemf_zc   <= step && !stuck;
    end
  end
endmodule // mcl_motor_model
